// file: rtl/rca_master.sv
// controller end of the two-wire register link, makes the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "rca_cfg.svh"
module rca_master
   import rca_pkg::*;
#(
   parameter int QTR_CYC = `RCA_QTR_CYC,
   parameter int WCW     = 8
)
(
   input  wire logic            ref_clk_i,
   input  wire logic            nrst_i,
   input  wire logic            target_sel_i,
   input  wire logic            cmd_valid_i,
   output logic                 cmd_ready_o,
   input  wire logic            cmd_read_i,
   input  wire logic [7:0]      cmd_reg_i,
   input  wire logic [WCW-1:0]  cmd_words_i,
   input  wire logic            wd_valid_i,
   output logic                 wd_ready_o,
   input  wire logic [15:0]     wd_data_i,
   output logic                 rd_valid_o,
   output logic [15:0]          rd_data_o,
   output logic                 done_o,
   output logic                 nack_o,
   rca_if.master                link
);

   localparam logic [15:0] QC_LAST = 16'(QTR_CYC - 1);

   rca_ms_state_t  state_reg;
   logic [15:0]    qcnt_reg;
   logic [1:0]     qtr_reg;
   logic [3:0]     bit_reg;
   logic           rep_reg;
   logic           rd_reg;
   logic           sel_reg;
   logic [7:0]     regh_reg;
   logic [WCW-1:0] words_reg;
   logic           half_reg;
   logic [7:0]     sh_reg;
   logic [7:0]     lo_reg;
   logic [7:0]     rx_reg;
   logic [7:0]     hi_rx_reg;
   logic           ack_in_reg;
   logic           sda_meta_reg;
   logic           sda_s_reg;
   logic           scl_reg;
   logic           oe_reg;
   logic           scl_next;
   logic           oe_next;
   logic           ticking;
   logic           tick;
   logic           sym_end;
   logic           is_byte;
   logic           byte_end;
   logic           last_word;

   assign ticking   = (state_reg != MS_IDLE) && (state_reg != MS_WAIT_W);
   assign tick      = ticking && (qcnt_reg == QC_LAST);
   assign sym_end   = tick && (qtr_reg == 2'h3);
   assign is_byte   = (state_reg == MS_ADDR_W) || (state_reg == MS_REG) ||
                      (state_reg == MS_WDATA) || (state_reg == MS_ADDR_R) ||
                      (state_reg == MS_RDATA);
   assign byte_end  = sym_end && is_byte && (bit_reg == `RCA_BIT_ACK);
   assign last_word = (words_reg == WCW'(1));

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         sda_meta_reg <= 1'b1;
         sda_s_reg    <= 1'b1;
      end
      else
      begin
         sda_meta_reg <= link.sda;
         sda_s_reg    <= sda_meta_reg;
      end
   end

   // each symbol is four quarters; clock high in quarters 1 and 2, in quarters 1 to 3 for stop
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         qcnt_reg <= 16'h0000;
         qtr_reg  <= 2'h0;
         bit_reg  <= 4'h0;
      end
      else
      begin
         if (!ticking)
         begin
            qcnt_reg <= 16'h0000;
            qtr_reg  <= 2'h0;
         end
         else if (tick)
         begin
            qcnt_reg <= 16'h0000;
            qtr_reg  <= qtr_reg + 1'b1;
         end
         else
            qcnt_reg <= qcnt_reg + 1'b1;
         if (!is_byte)
            bit_reg <= 4'h0;
         else if (sym_end)
            bit_reg <= (bit_reg == `RCA_BIT_ACK) ? 4'h0 : bit_reg + 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rx_reg     <= 8'h00;
         ack_in_reg <= 1'b1;
      end
      else if (tick && (qtr_reg == 2'h2) && is_byte)
      begin
         if (bit_reg == `RCA_BIT_ACK)
            ack_in_reg <= sda_s_reg;
         else
            rx_reg <= {rx_reg[6:0], sda_s_reg};
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_reg  <= MS_IDLE;
         rep_reg    <= 1'b0;
         rd_reg     <= 1'b0;
         sel_reg    <= 1'b0;
         regh_reg   <= 8'h00;
         words_reg  <= '0;
         half_reg   <= 1'b0;
         sh_reg     <= 8'hff;
         lo_reg     <= 8'h00;
         hi_rx_reg  <= 8'h00;
         rd_valid_o <= 1'b0;
         rd_data_o  <= 16'h0000;
         done_o     <= 1'b0;
         nack_o     <= 1'b0;
      end
      else
      begin
         rd_valid_o <= 1'b0;
         done_o     <= 1'b0;
         // ones shift in so the line is released after the byte
         if (sym_end && is_byte && (bit_reg != `RCA_BIT_ACK))
            sh_reg <= {sh_reg[6:0], 1'b1};
         unique case (state_reg)
            MS_IDLE:
               if (cmd_valid_i)
               begin
                  rd_reg    <= cmd_read_i;
                  sel_reg   <= target_sel_i;
                  regh_reg  <= cmd_reg_i;
                  words_reg <= (cmd_words_i == '0) ? WCW'(1) : cmd_words_i;
                  rep_reg   <= 1'b0;
                  nack_o    <= 1'b0;
                  state_reg <= MS_START;
               end
            MS_START:
               if (sym_end)
               begin
                  sh_reg    <= {`RCA_DEV_ADDR, sel_reg, rep_reg};
                  state_reg <= rep_reg ? MS_ADDR_R : MS_ADDR_W;
               end
            MS_ADDR_W, MS_ADDR_R:
               if (byte_end && ack_in_reg)
               begin
                  nack_o    <= 1'b1;
                  state_reg <= MS_STOP;
               end
               else if (byte_end)
               begin
                  sh_reg    <= regh_reg;
                  half_reg  <= 1'b0;
                  state_reg <= (state_reg == MS_ADDR_R) ? MS_RDATA : MS_REG;
               end
            MS_REG:
               if (byte_end && ack_in_reg)
               begin
                  nack_o    <= 1'b1;
                  state_reg <= MS_STOP;
               end
               else if (byte_end)
               begin
                  rep_reg   <= rd_reg;
                  state_reg <= rd_reg ? MS_START : MS_WAIT_W;
               end
            MS_WAIT_W:
               if (wd_valid_i)
               begin
                  sh_reg    <= wd_data_i[15:8];
                  lo_reg    <= wd_data_i[7:0];
                  half_reg  <= 1'b0;
                  state_reg <= MS_WDATA;
               end
            MS_WDATA:
               if (byte_end && ack_in_reg)
               begin
                  nack_o    <= 1'b1;
                  state_reg <= MS_STOP;
               end
               else if (byte_end && !half_reg)
               begin
                  sh_reg   <= lo_reg;
                  half_reg <= 1'b1;
               end
               else if (byte_end)
               begin
                  words_reg <= words_reg - 1'b1;
                  state_reg <= last_word ? MS_STOP : MS_WAIT_W;
               end
            MS_RDATA:
               if (byte_end && !half_reg)
               begin
                  hi_rx_reg <= rx_reg;
                  half_reg  <= 1'b1;
               end
               else if (byte_end)
               begin
                  rd_valid_o <= 1'b1;
                  rd_data_o  <= {hi_rx_reg, rx_reg};
                  half_reg   <= 1'b0;
                  words_reg  <= words_reg - 1'b1;
                  state_reg  <= last_word ? MS_STOP : MS_RDATA;
               end
            MS_STOP:
               if (sym_end)
               begin
                  done_o    <= 1'b1;
                  state_reg <= MS_IDLE;
               end
            default:
               state_reg <= MS_IDLE;
         endcase
      end
   end

   always_comb
   begin
      scl_next = 1'b1;
      oe_next  = 1'b0;
      unique case (state_reg)
         MS_IDLE:
            ;
         MS_START:
         begin
            scl_next = (qtr_reg == 2'h1) || (qtr_reg == 2'h2);
            oe_next  = qtr_reg[1];
         end
         MS_STOP:
         begin
            scl_next = (qtr_reg != 2'h0);
            oe_next  = ~qtr_reg[1];
         end
         MS_WAIT_W:
            scl_next = 1'b0;
         MS_ADDR_W, MS_REG, MS_WDATA, MS_ADDR_R:
         begin
            scl_next = (qtr_reg == 2'h1) || (qtr_reg == 2'h2);
            oe_next  = (bit_reg != `RCA_BIT_ACK) && !sh_reg[7];
         end
         MS_RDATA:
         begin
            scl_next = (qtr_reg == 2'h1) || (qtr_reg == 2'h2);
            oe_next  = (bit_reg == `RCA_BIT_ACK) && !(half_reg && last_word);
         end
         default:
            ;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_reg <= 1'b1;
         oe_reg  <= 1'b0;
      end
      else
      begin
         scl_reg <= scl_next;
         oe_reg  <= oe_next;
      end
   end

   assign link.scl      = scl_reg;
   assign link.m_sda_o  = 1'b0;
   assign link.m_sda_oe = oe_reg;
   assign cmd_ready_o   = (state_reg == MS_IDLE);
   assign wd_ready_o    = (state_reg == MS_WAIT_W);

endmodule : rca_master
`default_nettype wire

// file: rtl/rca_cfg.svh
// shared constants for the two-wire register link
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH
`define RCA_DEV_ADDR      6'h0d
`define RCA_RW_READ       1'b1
`define RCA_BIT_FIRST     4'd1
`define RCA_BIT_LAST      4'd7
`define RCA_BIT_ACK       4'd8
`define RCA_REG_AW        7
`define RCA_BIT_TIME_NS   10000
`define RCA_CLK_PERIOD_NS 8
`define RCA_QTR_CYC       (`RCA_BIT_TIME_NS / (4 * `RCA_CLK_PERIOD_NS))
`endif

// file: rtl/rca_pkg.sv
// state types for the two-wire register link
package rca_pkg;
   typedef enum logic [2:0] {
      SL_IDLE,
      SL_ADDR,
      SL_REG,
      SL_WDATA,
      SL_RDATA
   } rca_sl_state_t;
   typedef enum logic [3:0] {
      MS_IDLE,
      MS_START,
      MS_ADDR_W,
      MS_REG,
      MS_WAIT_W,
      MS_WDATA,
      MS_ADDR_R,
      MS_RDATA,
      MS_STOP
   } rca_ms_state_t;
endpackage : rca_pkg

// file: rtl/rca_if.sv
// two-wire link between register master and codec slave
`timescale 1ns/10ps
`default_nettype none
interface rca_if;
   logic scl;
   logic m_sda_o;
   logic m_sda_oe;
   logic s_sda_o;
   logic s_sda_oe;
   logic sda;
   // wired-and with pull-up
   assign sda = ~((m_sda_oe & ~m_sda_o) | (s_sda_oe & ~s_sda_o));
   modport master (output scl, output m_sda_o, output m_sda_oe, input sda);
   modport slave  (input scl, input sda, output s_sda_o, output s_sda_oe);
endinterface : rca_if
`default_nettype wire

// file: rtl/rca_slave.sv
// codec end of the two-wire register link, clocked by the serial clock
`timescale 1ns/10ps
`default_nettype none
`include "rca_cfg.svh"
module rca_slave
   import rca_pkg::*;
#(
   parameter int AW = `RCA_REG_AW
)
(
   input  wire logic          ref_clk_i,
   input  wire logic          nrst_i,
   input  wire logic          address_select_pin_i,
   rca_if.slave               link,
   output logic               wr_stb_o,
   output logic [AW-1:0]      wr_addr_o,
   output logic [15:0]        wr_data_o,
   output logic               busy_o
);

   rca_sl_state_t  state_reg;
   logic [3:0]     cnt_reg;
   logic [7:0]     shift_reg;
   logic           ack_pend_reg;
   logic           half_reg;
   logic [7:0]     reg_addr_reg;
   logic [7:0]     upper_reg;
   logic [15:0]    mem_reg [2**AW];
   logic           sel_meta_reg;
   logic           sel_s_reg;
   logic           start_tgl_reg;
   logic           start_mark_reg;
   logic           stop_mark_reg;
   logic           start_seen_reg;
   logic           oe_reg;
   logic           wr_tgl_reg;
   logic [AW-1:0]  wr_addr_hold_reg;
   logic [15:0]    wr_data_hold_reg;
   logic           wt_meta_reg;
   logic           wt_s_reg;
   logic           wt_d_reg;
   logic           busy_meta_reg;
   logic           busy_s_reg;

   logic           start_new;
   logic           in_frame;
   logic [7:0]     byte_in;
   logic           ack_slot;
   logic           byte_done;
   logic           addr_hit;
   logic           commit;
   logic [AW-1:0]  idx;
   logic [15:0]    rd_word;
   logic [7:0]     tx_byte;

   // start and stop are data edges while the clock is high
   always_ff @(negedge link.sda or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         start_tgl_reg  <= 1'b0;
         start_mark_reg <= 1'b0;
      end
      else if (link.scl)
      begin
         start_tgl_reg  <= ~start_tgl_reg;
         start_mark_reg <= ~stop_mark_reg;
      end
   end

   always_ff @(posedge link.sda or negedge nrst_i)
   begin
      if (!nrst_i)
         stop_mark_reg <= 1'b0;
      else if (link.scl)
         stop_mark_reg <= start_mark_reg;
   end

   // start flops settle three quarters of a clock period before the next rising edge
   assign start_new = start_tgl_reg ^ start_seen_reg;
   assign in_frame  = start_mark_reg ^ stop_mark_reg;
   assign byte_in   = {shift_reg[6:0], link.sda};
   assign ack_slot  = in_frame && !start_new && (cnt_reg == `RCA_BIT_ACK);
   assign byte_done = in_frame && !start_new && (cnt_reg == `RCA_BIT_LAST);
   assign addr_hit  = (byte_in[7:1] == {`RCA_DEV_ADDR, sel_s_reg});
   assign commit    = byte_done && (state_reg == SL_WDATA) && half_reg;
   assign idx       = reg_addr_reg[AW-1:0];
   assign rd_word   = mem_reg[idx];
   assign tx_byte   = half_reg ? rd_word[7:0] : rd_word[15:8];

   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         start_seen_reg <= 1'b0;
         sel_meta_reg   <= 1'b0;
         sel_s_reg      <= 1'b0;
      end
      else
      begin
         start_seen_reg <= start_tgl_reg;
         sel_meta_reg   <= address_select_pin_i;
         sel_s_reg      <= sel_meta_reg;
      end
   end

   // bit counter: 0..7 data bits, 8 the acknowledge slot
   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
      end
      else if (start_new)
      begin
         cnt_reg   <= `RCA_BIT_FIRST;
         shift_reg <= {7'h00, link.sda};
      end
      else if (!in_frame || (cnt_reg == `RCA_BIT_ACK))
         cnt_reg <= 4'h0;
      else
      begin
         cnt_reg   <= cnt_reg + 1'b1;
         shift_reg <= byte_in;
      end
   end

   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
         state_reg <= SL_IDLE;
      else if (start_new)
         state_reg <= SL_ADDR;
      else if (!in_frame)
         state_reg <= SL_IDLE;
      else if (ack_slot && (state_reg == SL_RDATA) && link.sda)
         state_reg <= SL_IDLE;
      else if (byte_done)
      begin
         unique case (state_reg)
            SL_ADDR:
               if (!addr_hit)
                  state_reg <= SL_IDLE;
               else if (byte_in[0] == `RCA_RW_READ)
                  state_reg <= SL_RDATA;
               else
                  state_reg <= SL_REG;
            SL_REG:
               state_reg <= SL_WDATA;
            SL_IDLE, SL_WDATA, SL_RDATA:
               ;
            default:
               state_reg <= SL_IDLE;
         endcase
      end
   end

   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
         ack_pend_reg <= 1'b0;
      else if (start_new || !in_frame || ack_slot)
         ack_pend_reg <= 1'b0;
      else if (byte_done)
      begin
         if (state_reg == SL_ADDR)
            ack_pend_reg <= addr_hit;
         else
            ack_pend_reg <= (state_reg == SL_REG) || (state_reg == SL_WDATA);
      end
   end

   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         reg_addr_reg <= 8'h00;
         half_reg     <= 1'b0;
         upper_reg    <= 8'h00;
      end
      else if (start_new || !in_frame)
         half_reg <= 1'b0;
      // address ack of a read still has ack_pend set; only data acks flip the half
      else if (ack_slot && (state_reg == SL_RDATA) && !ack_pend_reg)
      begin
         half_reg <= ~half_reg;
         if (half_reg)
            reg_addr_reg <= reg_addr_reg + 1'b1;
      end
      else if (byte_done && (state_reg == SL_REG))
      begin
         reg_addr_reg <= byte_in;
         half_reg     <= 1'b0;
      end
      else if (byte_done && (state_reg == SL_WDATA))
      begin
         half_reg <= ~half_reg;
         if (!half_reg)
            upper_reg <= byte_in;
         else
            reg_addr_reg <= reg_addr_reg + 1'b1;
      end
   end

   // whole word lands at once, never half of a pair
   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         for (int i = 0; i < 2**AW; i++)
            mem_reg[i] <= 16'h0000;
      end
      else if (commit)
         mem_reg[idx] <= {upper_reg, byte_in};
   end

   // hold words stay put for a whole pair, far longer than the sync
   always_ff @(posedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_tgl_reg       <= 1'b0;
         wr_addr_hold_reg <= '0;
         wr_data_hold_reg <= 16'h0000;
      end
      else if (commit)
      begin
         wr_tgl_reg       <= ~wr_tgl_reg;
         wr_addr_hold_reg <= idx;
         wr_data_hold_reg <= {upper_reg, byte_in};
      end
   end

   // data changes only while the clock is low
   always_ff @(negedge link.scl or negedge nrst_i)
   begin
      if (!nrst_i)
         oe_reg <= 1'b0;
      else if (cnt_reg == `RCA_BIT_ACK)
         oe_reg <= ack_pend_reg;
      else if ((state_reg == SL_RDATA) && in_frame)
         oe_reg <= ~tx_byte[~cnt_reg[2:0]];
      else
         oe_reg <= 1'b0;
   end

   assign link.s_sda_o  = 1'b0;
   assign link.s_sda_oe = oe_reg;

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wt_meta_reg   <= 1'b0;
         wt_s_reg      <= 1'b0;
         wt_d_reg      <= 1'b0;
         busy_meta_reg <= 1'b0;
         busy_s_reg    <= 1'b0;
      end
      else
      begin
         wt_meta_reg   <= wr_tgl_reg;
         wt_s_reg      <= wt_meta_reg;
         wt_d_reg      <= wt_s_reg;
         busy_meta_reg <= in_frame;
         busy_s_reg    <= busy_meta_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wr_stb_o  <= 1'b0;
         wr_addr_o <= '0;
         wr_data_o <= 16'h0000;
      end
      else
      begin
         wr_stb_o <= wt_s_reg ^ wt_d_reg;
         if (wt_s_reg ^ wt_d_reg)
         begin
            wr_addr_o <= wr_addr_hold_reg;
            wr_data_o <= wr_data_hold_reg;
         end
      end
   end

   assign busy_o = busy_s_reg;

endmodule : rca_slave
`default_nettype wire

// file: tb/rca_link_properties.sv
// assertion checker watching the two-wire link between the two ends
`timescale 1ns/10ps
`default_nettype none
`include "rca_cfg.svh"
module rca_link_properties (
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   input wire logic address_select_pin_i,
   input wire logic scl,
   input wire logic m_sda_oe,
   input wire logic s_sda_o,
   input wire logic s_sda_oe,
   input wire logic sda
);
   logic       scl_reg;
   logic       sda_reg;
   logic       rd_reg;
   logic       nack_reg;
   logic [3:0] bit_reg;
   logic [1:0] byte_reg;
   logic [7:0] shift_reg;
   wire        start_ev = scl & scl_reg & sda_reg & ~sda;
   wire        ack_ev   = scl & ~scl_reg & (bit_reg == 4'h8);
   wire        bit_ev   = scl & ~scl_reg & (bit_reg != 4'h8);

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         scl_reg <= 1'h1;
         sda_reg <= 1'h1;
      end
      else
      begin
         scl_reg <= scl;
         sda_reg <= sda;
      end
   end

   // frame position rebuilt from the wire alone, so neither end judges itself
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         bit_reg  <= 4'h0;
         byte_reg <= 2'h0;
         rd_reg   <= 1'h0;
         nack_reg <= 1'h0;
      end
      else if (start_ev)
      begin
         bit_reg  <= 4'h0;
         byte_reg <= 2'h0;
         rd_reg   <= 1'h0;
         nack_reg <= 1'h0;
      end
      else if (ack_ev)
      begin
         bit_reg  <= 4'h0;
         byte_reg <= (byte_reg == 2'h2) ? 2'h2 : byte_reg + 2'h1;
         nack_reg <= nack_reg | (rd_reg & (byte_reg != 2'h0) & sda);
      end
      else if (bit_ev)
      begin
         bit_reg <= bit_reg + 4'h1;
         rd_reg  <= (bit_reg == 4'h7 && byte_reg == 2'h0) ? sda : rd_reg;
      end
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (bit_ev)
         shift_reg <= {shift_reg[6:0], sda};
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!nrst_i);

   AST_ADDR_ACK: assert property (ack_ev && byte_reg == 2'h0
      |-> s_sda_oe == (shift_reg[7:1] == {`RCA_DEV_ADDR, address_select_pin_i}))
      else $error("address acknowledge wrong");
   AST_REG_ACK: assert property (ack_ev && byte_reg == 2'h1 && !rd_reg |-> s_sda_oe)
      else $error("register byte not acknowledged");
   AST_DATA_ACK: assert property (ack_ev && byte_reg == 2'h2 && !rd_reg |-> s_sda_oe)
      else $error("write data byte not acknowledged");
   AST_READ_MASTER_QUIET: assert property (bit_ev && rd_reg && byte_reg != 2'h0
      && !nack_reg |-> !m_sda_oe)
      else $error("controller drives during read data");
   AST_WRITE_SLAVE_QUIET: assert property (bit_ev && !rd_reg |-> !s_sda_oe)
      else $error("codec drives during written bits");
   AST_NACK_RELEASE: assert property (nack_reg |-> !s_sda_oe)
      else $error("data line held after refusal");
   AST_STOP_AFTER_NACK: assert property (ack_ev && rd_reg && byte_reg != 2'h0 && sda
      |-> ##[1:64] (scl && sda && !sda_reg))
      else $error("no stop after read refusal");
   AST_EDGE_SCL_LOW: assert property ($changed(s_sda_oe) |-> !scl)
      else $error("codec changed data with clock high");
   AST_OPEN_DRAIN: assert property (s_sda_oe |-> !s_sda_o)
      else $error("codec drives data high");
endmodule : rca_link_properties
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench: controller and codec ends joined over the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); \
      end \
   end
module tb_top;
   logic        ref_clk_i = 1'b0;
   logic        nrst_i    = 1'b0;
   logic        pin       = 1'b0;
   logic        tsel      = 1'b0;
   logic        cmd_valid = 1'b0;
   logic        cmd_read  = 1'b0;
   logic [7:0]  cmd_reg   = 8'h00;
   logic [7:0]  cmd_words = 8'h00;
   logic        wd_valid  = 1'b0;
   logic [15:0] wd_data   = 16'h0000;
   logic        cmd_ready;
   logic        wd_ready;
   logic        rd_valid;
   logic [15:0] rd_data;
   logic        done;
   logic        nack;
   logic        busy;
   logic        wr_stb;
   logic [6:0]  wr_addr;
   logic [15:0] wr_data;
   logic [22:0] wq[$];
   logic [15:0] rq[$];
   int          failures = 0;
   int          samples_checked = 0;

   rca_if link_if ();
   rca_master #(.QTR_CYC(4)) i_rca_master (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .target_sel_i(tsel),
      .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read),
      .cmd_reg_i(cmd_reg), .cmd_words_i(cmd_words), .wd_valid_i(wd_valid),
      .wd_ready_o(wd_ready), .wd_data_i(wd_data), .rd_valid_o(rd_valid),
      .rd_data_o(rd_data), .done_o(done), .nack_o(nack), .link(link_if));
   rca_slave i_rca_slave (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .address_select_pin_i(pin),
      .link(link_if), .wr_stb_o(wr_stb), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
      .busy_o(busy));
   rca_link_properties i_rca_link_properties (
      .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .address_select_pin_i(pin),
      .scl(link_if.scl), .m_sda_oe(link_if.m_sda_oe), .s_sda_o(link_if.s_sda_o),
      .s_sda_oe(link_if.s_sda_oe), .sda(link_if.sda));

   always #4 ref_clk_i = ~ref_clk_i;

   // sampled mid-cycle so registered pulses are settled
   always @(negedge ref_clk_i)
   begin
      if (wr_stb === 1'b1)
         wq.push_back({wr_addr, wr_data});
      if (rd_valid === 1'b1)
         rq.push_back(rd_data);
   end

   function automatic logic [15:0] word(input logic [15:0] b, input int i);
      return b + 16'(i) * 16'h0101;
   endfunction : word

   task automatic complete_run();
      $display("comparisons %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : complete_run

   // one command; write words are offered with growing delay, each ready before the controller waits, so the link never stalls
   task automatic xfer(input logic rd, input logic [7:0] ra, input int n, input logic ts,
                       input logic [15:0] base);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b1;
      cmd_read  <= rd;
      cmd_reg   <= ra;
      cmd_words <= 8'(n);
      tsel      <= ts;
      do
         @(negedge ref_clk_i);
      while (cmd_ready !== 1'b1);
      @(posedge ref_clk_i);
      cmd_valid <= 1'b0;
      for (int i = 0; i < n && rd == 1'b0; i++)
      begin
         repeat (3 * i) @(posedge ref_clk_i);
         wd_valid <= 1'b1;
         wd_data  <= word(base, i);
         do
            @(negedge ref_clk_i);
         while (wd_ready !== 1'b1);
         `CHK(busy, 1'b1)
         @(posedge ref_clk_i);
         wd_valid <= 1'b0;
      end
      while (done !== 1'b1)
         @(negedge ref_clk_i);
      `CHK(busy, 1'b0)
   endtask : xfer

   task automatic check_q(input logic rd, input logic [6:0] ra, input int n,
                          input logic [15:0] base);
      logic [22:0] got;
      `CHK(rd ? rq.size() : wq.size(), n)
      for (int i = 0; i < n; i++)
      begin
         // popped once so a mismatch report does not eat the next entry
         got = rd ? {7'h00, rq.pop_front()} : wq.pop_front();
         if (rd)
            `CHK(got[15:0], word(base, i))
         else
            `CHK(got, {ra + 7'(i), word(base, i)})
      end
   endtask : check_q

   initial
   begin
      repeat (20) @(posedge ref_clk_i);
      nrst_i <= 1'b1;
      xfer(1'b0, 8'h10, 3, 1'b0, 16'ha55a);
      check_q(1'b0, 7'h10, 3, 16'ha55a);
      `CHK(nack, 1'b0)
      $display("write burst test finished");
      xfer(1'b1, 8'h10, 3, 1'b0, 16'h0000);
      check_q(1'b1, 7'h10, 3, 16'ha55a);
      xfer(1'b1, 8'h13, 1, 1'b0, 16'h0000);
      check_q(1'b1, 7'h13, 1, 16'h0000);
      `CHK(nack, 1'b0)
      $display("read burst test finished");
      for (int s = 0; s < 2; s++)
      begin
         @(posedge ref_clk_i);
         pin <= 1'(s);
         xfer(1'b0, 8'h40, 0, ~1'(s), 16'h0000);
         `CHK(nack, 1'b1)
         check_q(1'b0, 7'h40, 0, 16'h0000);
         xfer(1'b0, 8'h7f, 2, 1'(s), 16'h1234 + 16'(s));
         `CHK(nack, 1'b0)
         check_q(1'b0, 7'h7f, 2, 16'h1234 + 16'(s));
         xfer(1'b1, 8'h7f, 2, 1'(s), 16'h0000);
         check_q(1'b1, 7'h7f, 2, 16'h1234 + 16'(s));
         $display("select level %0d test finished", s);
      end
      complete_run();
   end

   initial
   begin
      repeat (40000) @(posedge ref_clk_i);
      failures++;
      complete_run();
   end
endmodule : tb_top
`default_nettype wire
